// *** adsc_pkg.sv ***
// package of register map, fields and timing for the converter control
package adsc_pkg;
  localparam logic [7:0] OFF_PORT_A = 8'h05;
  localparam logic [7:0] OFF_INT_CTRL = 8'h0B;
  localparam logic [7:0] OFF_PERIPH_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h1E;
  localparam logic [7:0] OFF_CTRL_0 = 8'h1F;
  localparam logic [7:0] OFF_PORT_A_DIR = 8'h85;
  localparam logic [7:0] OFF_PERIPH_EN = 8'h8C;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h9E;
  localparam logic [7:0] OFF_CTRL_1 = 8'h9F;
  localparam logic [7:0] RST_CTRL_0 = 8'h00;
  localparam logic [7:0] RST_CTRL_1 = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] RST_PORT_A_DIR = 8'hFF;
  // control 0 fields
  localparam int CTRL0_ENABLE = 0;
  localparam int CTRL0_GO = 2;
  localparam int CTRL0_CHAN_LSB = 3;
  localparam int CTRL0_CLK_LSB = 6;
  // control 1 fields
  localparam int CTRL1_FORMAT = 7;
  localparam int CTRL1_DIV2 = 6;
  localparam logic [7:0] CTRL1_WMASK = 8'hCF;
  localparam logic [7:0] CTRL0_WMASK = 8'hFD;
  // flags / enables bit
  localparam int PERIPH_ADC_BIT = 6;
  localparam logic [7:0] PERIPH_WMASK = 8'h4F;
  localparam int INT_GLOBAL_BIT = 7;
  localparam int INT_PERIPH_BIT = 6;
  localparam logic [1:0] CLK_FIELD_RC = 2'h3;
  localparam logic [3:0] COMPARE_TRIGGER_MODE = 4'hB;
  // timing in conversion clock periods
  localparam int CONV_PERIODS = 9;
  localparam int ABORT_WAIT_PERIODS = 2;
  localparam int RESULT_BITS = 10;
  localparam int ANALOG_CHANNELS = 5;
  // instruction cycle is four oscillator periods
  localparam int OSC_PER_INSTR = 4;
  typedef enum logic [2:0] {
    ADSC_IDLE, ADSC_FIRST, ADSC_CONVERT, ADSC_WAIT
  } adsc_state_t;
endpackage : adsc_pkg

// *** adsc_clock_div.sv ***
// conversion clock enable generator: oscillator divider or rc clock
`timescale 1ns/1ps
`default_nettype none
module adsc_clock_div (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic div2_in,
  input wire logic [1:0] field_in,
  input wire logic rc_tick_in,
  output logic tick_out
);
  logic [5:0] count_reg;
  logic [5:0] limit;

  // period of 2,8,32 tosc, doubled by the divide-by-two bit
  always_comb
  begin
    unique case (field_in)
      2'h0: limit = 6'h01;
      2'h1: limit = 6'h07;
      default: limit = 6'h1F;
    endcase
    if (div2_in)
    begin
      limit = {limit[4:0], 1'b1};
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in || !run_in)
    begin
      count_reg <= 6'h00;
      tick_out <= 1'b0;
    end
    else if (field_in == adsc_pkg::CLK_FIELD_RC)
    begin
      count_reg <= 6'h00;
      tick_out <= rc_tick_in;
    end
    else if (count_reg >= limit)
    begin
      count_reg <= 6'h00;
      tick_out <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 6'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // adsc_clock_div
`default_nettype wire

// *** adsc_control.sv ***
// converter sequencing control with its register file
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - analog-configured port pins read as zero
// - divide bit and clock field pick period
// - converts regardless of channel and direction
// - clearing status aborts, result kept
// - two periods wait after abort
// - first segment between instruction and period
// - result loaded justified, zeros elsewhere
// - result registers writable while disabled
// - sleep conversion only with rc clock
// - sleep completion clears, loads, wakes if the converter interrupt enable is set
// - sleep aborts non-rc conversion, powers down
// - reset clears registers, aborts, pins analog
// - power-on reset leaves result untouched
// - trigger in mode 1011 starts, clears timer
// - disabled converter ignores trigger, clears timer
// - completion loads result, clears status, flags
// - nine conversion clock periods per conversion
// - format one right, zero left justified
// - channel codes zero to four select inputs
module adsc_control #(
  parameter int RESULT_BITS = adsc_pkg::RESULT_BITS,
  parameter int CHANNELS = adsc_pkg::ANALOG_CHANNELS
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic power_on_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] pins_in,
  input wire logic sleep_in,
  input wire logic rc_tick_in,
  input wire logic [3:0] compare_mode_in,
  input wire logic special_trigger_in,
  input wire logic [RESULT_BITS-1:0] sample_in,
  output logic [2:0] channel_out,
  output logic sample_hold_out,
  output logic powered_out,
  output logic [7:0] port_a_direction_out,
  output logic timer_clear_out,
  output logic wake_out,
  output logic interrupt_request_out
);
  adsc_pkg::adsc_state_t state_reg;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] result_high_reg;
  logic [7:0] result_low_reg;
  logic [7:0] int_ctrl_reg;
  logic [7:0] flags_reg;
  logic [7:0] enables_reg;
  logic [7:0] pins_meta_reg;
  logic [7:0] pins_sync_reg;
  logic [3:0] period_count_reg;
  logic [2:0] instr_count_reg;
  logic [RESULT_BITS-1:0] sar_reg;
  logic sleep_meta_reg;
  logic sleep_sync_reg;
  logic trig_meta_reg;
  logic trig_sync_reg;
  logic trig_prev_reg;
  logic rc_meta_reg;
  logic rc_sync_reg;
  logic rc_prev_reg;
  logic down_reg;
  logic tick;
  logic rc_edge;
  logic trig_edge;
  logic is_rc;
  logic enabled;
  logic go_bit;
  logic write_ctrl0;
  logic start;
  logic abort;
  logic done;
  logic [7:0] analog_mask;
  logic [15:0] justified;

  // pins whose analog configuration code marks them analog
  function automatic logic [7:0] analog_pins(input logic [3:0] cfg);
    unique case (cfg)
      4'h4: analog_pins = 8'h0B;
      4'h5: analog_pins = 8'h03;
      4'h6, 4'h7: analog_pins = 8'h00;
      4'h8, 4'hB, 4'hC: analog_pins = 8'h1F;
      4'hD: analog_pins = 8'h0F;
      4'hE: analog_pins = 8'h01;
      4'hF: analog_pins = 8'h0D;
      default: analog_pins = 8'h1F;
    endcase
  endfunction

  assign is_rc = ctrl0_reg[7:6] == adsc_pkg::CLK_FIELD_RC;
  assign enabled = ctrl0_reg[adsc_pkg::CTRL0_ENABLE];
  assign go_bit = ctrl0_reg[adsc_pkg::CTRL0_GO];
  assign write_ctrl0 = write_in && addr_in == adsc_pkg::OFF_CTRL_0;
  assign analog_mask = analog_pins(ctrl1_reg[3:0]);
  assign rc_edge = rc_sync_reg && !rc_prev_reg;
  assign trig_edge = trig_sync_reg && !trig_prev_reg;
  // software start needs the enable already set
  assign start = state_reg == adsc_pkg::ADSC_IDLE && enabled && !down_reg
    && ((write_ctrl0 && wdata_in[adsc_pkg::CTRL0_GO] && !go_bit)
    || (trig_edge && compare_mode_in == adsc_pkg::COMPARE_TRIGGER_MODE));
  assign abort = (state_reg == adsc_pkg::ADSC_FIRST
    || state_reg == adsc_pkg::ADSC_CONVERT)
    && ((write_ctrl0 && !wdata_in[adsc_pkg::CTRL0_GO])
    || !enabled || (sleep_sync_reg && !is_rc));
  assign done = state_reg == adsc_pkg::ADSC_CONVERT && tick && !abort
    && period_count_reg == 4'(adsc_pkg::CONV_PERIODS - 1);
  assign justified = ctrl1_reg[adsc_pkg::CTRL1_FORMAT]
    ? {6'h00, sar_reg}
    : {sar_reg, 6'h00};

  adsc_clock_div u_div (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .run_in(state_reg != adsc_pkg::ADSC_IDLE),
    .div2_in(ctrl1_reg[adsc_pkg::CTRL1_DIV2]),
    .field_in(ctrl0_reg[7:6]),
    .rc_tick_in(rc_edge),
    .tick_out(tick)
  );

  // two-stage synchronisers for outside inputs
  always_ff @(posedge clock_in)
  begin
    pins_meta_reg <= pins_in;
    pins_sync_reg <= pins_meta_reg;
    sleep_meta_reg <= sleep_in;
    sleep_sync_reg <= sleep_meta_reg;
    trig_meta_reg <= special_trigger_in;
    trig_sync_reg <= trig_meta_reg;
    rc_meta_reg <= rc_tick_in;
    rc_sync_reg <= rc_meta_reg;
    if (reset_in)
    begin
      trig_prev_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end
    else
    begin
      trig_prev_reg <= trig_sync_reg;
      rc_prev_reg <= rc_sync_reg;
    end
  end

  // conversion sequencer
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      state_reg <= adsc_pkg::ADSC_IDLE;
      period_count_reg <= 4'h0;
      instr_count_reg <= 3'h0;
      sar_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        adsc_pkg::ADSC_IDLE:
        begin
          period_count_reg <= 4'h0;
          instr_count_reg <= 3'h0;
          if (start)
          begin
            state_reg <= adsc_pkg::ADSC_FIRST;
          end
        end
        adsc_pkg::ADSC_FIRST:
        begin
          // hold at least one instruction cycle, end on a period tick
          if (instr_count_reg != 3'(adsc_pkg::OSC_PER_INSTR - 1))
          begin
            instr_count_reg <= instr_count_reg + 3'h1;
          end
          if (abort)
          begin
            state_reg <= adsc_pkg::ADSC_WAIT;
          end
          else if (tick
            && instr_count_reg == 3'(adsc_pkg::OSC_PER_INSTR - 1))
          begin
            state_reg <= adsc_pkg::ADSC_CONVERT;
            period_count_reg <= 4'h1;
            sar_reg <= sample_in;
          end
        end
        adsc_pkg::ADSC_CONVERT:
        begin
          if (abort)
          begin
            state_reg <= adsc_pkg::ADSC_WAIT;
            period_count_reg <= 4'h0;
          end
          else if (done)
          begin
            state_reg <= adsc_pkg::ADSC_WAIT;
            period_count_reg <= 4'h0;
          end
          else if (tick)
          begin
            period_count_reg <= period_count_reg + 4'h1;
          end
        end
        adsc_pkg::ADSC_WAIT:
        begin
          if (tick)
          begin
            period_count_reg <= period_count_reg + 4'h1;
            if (period_count_reg == 4'(adsc_pkg::ABORT_WAIT_PERIODS - 1))
            begin
              state_reg <= adsc_pkg::ADSC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // control register 0: status bit set by start, cleared by completion
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ctrl0_reg <= adsc_pkg::RST_CTRL_0;
    end
    else
    begin
      if (write_ctrl0)
      begin
        ctrl0_reg <= wdata_in & adsc_pkg::CTRL0_WMASK;
        ctrl0_reg[adsc_pkg::CTRL0_GO] <= wdata_in[adsc_pkg::CTRL0_GO]
          && go_bit;
      end
      if (start)
      begin
        ctrl0_reg[adsc_pkg::CTRL0_GO] <= 1'b1;
      end
      else if (done || abort)
      begin
        ctrl0_reg[adsc_pkg::CTRL0_GO] <= 1'b0;
      end
    end
  end

  // power-down while enabled: sleep with no wake, or non-rc sleep
  always_ff @(posedge clock_in)
  begin
    if (reset_in || !enabled || !sleep_sync_reg)
    begin
      down_reg <= 1'b0;
    end
    else if ((done && !enables_reg[adsc_pkg::PERIPH_ADC_BIT])
      || !is_rc)
    begin
      down_reg <= 1'b1;
    end
  end

  // remaining software registers
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ctrl1_reg <= adsc_pkg::RST_CTRL_1;
      int_ctrl_reg <= adsc_pkg::RST_INT_CTRL;
      enables_reg <= adsc_pkg::RST_PERIPH;
      port_a_direction_out <= adsc_pkg::RST_PORT_A_DIR;
    end
    else if (write_in)
    begin
      unique case (addr_in)
        adsc_pkg::OFF_CTRL_1: ctrl1_reg <= wdata_in & adsc_pkg::CTRL1_WMASK;
        adsc_pkg::OFF_INT_CTRL: int_ctrl_reg <= wdata_in;
        adsc_pkg::OFF_PERIPH_EN:
          enables_reg <= wdata_in & adsc_pkg::PERIPH_WMASK;
        adsc_pkg::OFF_PORT_A_DIR: port_a_direction_out <= wdata_in;
        default: ;
      endcase
    end
  end

  // interrupt flag: hardware set wins over software clear
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      flags_reg <= adsc_pkg::RST_PERIPH;
    end
    else
    begin
      if (write_in && addr_in == adsc_pkg::OFF_PERIPH_FLAGS)
      begin
        flags_reg <= wdata_in & adsc_pkg::PERIPH_WMASK;
      end
      if (done)
      begin
        flags_reg[adsc_pkg::PERIPH_ADC_BIT] <= 1'b1;
      end
    end
  end

  // result pair: untouched by any reset, loaded at completion or by a write while disabled
  always_ff @(posedge clock_in)
  begin
    if (done)
    begin
      result_high_reg <= justified[15:8];
      result_low_reg <= justified[7:0];
    end
    else if (write_in && !enabled)
    begin
      if (addr_in == adsc_pkg::OFF_RESULT_HIGH)
      begin
        result_high_reg <= wdata_in;
      end
      if (addr_in == adsc_pkg::OFF_RESULT_LOW)
      begin
        result_low_reg <= wdata_in;
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clock_in)
  begin
    if (reset_in || !read_in)
    begin
      rdata_out <= 8'h00;
    end
    else
    begin
      unique case (addr_in)
        adsc_pkg::OFF_PORT_A: rdata_out <= pins_sync_reg & ~analog_mask;
        adsc_pkg::OFF_INT_CTRL: rdata_out <= int_ctrl_reg;
        adsc_pkg::OFF_PERIPH_FLAGS: rdata_out <= flags_reg;
        adsc_pkg::OFF_RESULT_HIGH: rdata_out <= result_high_reg;
        adsc_pkg::OFF_CTRL_0: rdata_out <= ctrl0_reg;
        adsc_pkg::OFF_PORT_A_DIR: rdata_out <= port_a_direction_out;
        adsc_pkg::OFF_PERIPH_EN: rdata_out <= enables_reg;
        adsc_pkg::OFF_RESULT_LOW: rdata_out <= result_low_reg;
        adsc_pkg::OFF_CTRL_1: rdata_out <= ctrl1_reg;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

  // outputs to analog front end, timer and core
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      channel_out <= 3'h0;
      sample_hold_out <= 1'b0;
      powered_out <= 1'b0;
      timer_clear_out <= 1'b0;
      wake_out <= 1'b0;
      interrupt_request_out <= 1'b0;
    end
    else
    begin
      channel_out <= ctrl0_reg[5:3];
      sample_hold_out <= state_reg != adsc_pkg::ADSC_IDLE;
      powered_out <= enabled && !down_reg;
      timer_clear_out <= trig_edge
        && compare_mode_in == adsc_pkg::COMPARE_TRIGGER_MODE;
      wake_out <= done && sleep_sync_reg
        && enables_reg[adsc_pkg::PERIPH_ADC_BIT];
      interrupt_request_out <= flags_reg[adsc_pkg::PERIPH_ADC_BIT]
        && enables_reg[adsc_pkg::PERIPH_ADC_BIT]
        && int_ctrl_reg[adsc_pkg::INT_PERIPH_BIT]
        && int_ctrl_reg[adsc_pkg::INT_GLOBAL_BIT];
    end
  end
endmodule // adsc_control
`default_nettype wire

// *** adsc_control_props.sv ***
// port assertions for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
module adsc_control_props (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic [3:0] compare_mode_in,
  input wire logic special_trigger_in,
  input wire logic [2:0] channel_out,
  input wire logic powered_out,
  input wire logic [7:0] port_a_direction_out,
  input wire logic timer_clear_out,
  input wire logic sample_hold_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  wire w0 = write_in && addr_in == adsc_pkg::OFF_CTRL_0;
  wire md = compare_mode_in == adsc_pkg::COMPARE_TRIGGER_MODE;
  property p_rdata_quiet;
    !read_in |=> rdata_out == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside read");
  property p_reset_out;
    disable iff (1'b0) reset_in ##1 reset_in |=> !powered_out &&
      port_a_direction_out == 8'hFF && !sample_hold_out && !timer_clear_out;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not at reset values");
  property p_dir;
    write_in && addr_in == adsc_pkg::OFF_PORT_A_DIR ##1 !write_in
      |=> port_a_direction_out == $past(wdata_in, 2);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction output not written value");
  property p_chan;
    w0 ##1 !write_in |=> channel_out == $past(wdata_in[5:3], 2);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel output not written field");
  property p_off;
    w0 && !wdata_in[0] ##1 !write_in |=> !powered_out;
  endproperty
  a_off: assert property (p_off)
    else $error("powered while enable clear");
  property p_trig;
    $rose(special_trigger_in) && md |-> ##[1:6] timer_clear_out;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not clear timer");
  property p_mode;
    timer_clear_out |-> $past(md);
  endproperty
  a_mode: assert property (p_mode)
    else $error("timer clear outside trigger mode");
  property p_pulse;
    timer_clear_out |=> !timer_clear_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("timer clear longer than one cycle");
endmodule // adsc_control_props
`default_nettype wire

// *** adsc_control_tb.sv ***
// self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
module adsc_control_tb;
  localparam logic [7:0] C0 = adsc_pkg::OFF_CTRL_0;
  localparam logic [7:0] C1 = adsc_pkg::OFF_CTRL_1;
  localparam logic [7:0] RH = adsc_pkg::OFF_RESULT_HIGH;
  localparam logic [7:0] RL = adsc_pkg::OFF_RESULT_LOW;
  localparam logic [7:0] FL = adsc_pkg::OFF_PERIPH_FLAGS;
  localparam logic [7:0] PA = adsc_pkg::OFF_PORT_A;
  // rows: write flag, address, write data or expected read data
  localparam logic [16:0] ROWS [22] = '{
    {1'b0, C0, 8'h00}, {1'b0, C1, 8'h00},
    {1'b0, adsc_pkg::OFF_PORT_A_DIR, 8'hFF}, {1'b0, FL, 8'h00},
    {1'b0, adsc_pkg::OFF_PERIPH_EN, 8'h00},
    {1'b0, adsc_pkg::OFF_INT_CTRL, 8'h00}, {1'b0, 8'h40, 8'h00},
    {1'b0, PA, 8'hE0}, {1'b1, C1, 8'h06}, {1'b0, PA, 8'hFF},
    {1'b1, C1, 8'h0E}, {1'b0, PA, 8'hFE}, {1'b1, RH, 8'hA5},
    {1'b1, RL, 8'h5A}, {1'b0, RH, 8'hA5}, {1'b0, RL, 8'h5A},
    {1'b1, C0, 8'h05}, {1'b0, C0, 8'h01}, {1'b1, RH, 8'h11},
    {1'b0, RH, 8'hA5}, {1'b1, adsc_pkg::OFF_PORT_A_DIR, 8'h3C},
    {1'b0, adsc_pkg::OFF_PORT_A_DIR, 8'h3C}};
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic slp = 1'b0, rc = 1'b0, trig = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, pins = 8'hFF, rdata, dir;
  logic [3:0] mode = 4'hB;
  logic [9:0] smp = 10'h000;
  logic [2:0] chan;
  logic hold, pwr, tclr, wake, irq;
  int fails = 0, checks_done = 0, cyc = 0, nclr = 0, nwk = 0;
  always #2 clk = ~clk;
  always #250 rc = ~rc;
  adsc_control adsc_control_i (.clock_in(clk), .reset_in(rst),
    .power_on_reset_in(por), .addr_in(addr), .wdata_in(wdata),
    .write_in(wr_s), .read_in(rd_s), .rdata_out(rdata), .pins_in(pins),
    .sleep_in(slp), .rc_tick_in(rc), .compare_mode_in(mode),
    .special_trigger_in(trig), .sample_in(smp), .channel_out(chan),
    .sample_hold_out(hold), .powered_out(pwr),
    .port_a_direction_out(dir), .timer_clear_out(tclr),
    .wake_out(wake), .interrupt_request_out(irq));
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cycle count, timer clear pulse count and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    nclr <= nclr + int'(tclr);
    nwk <= nwk + int'(wake);
    if (cyc == 20000)
    begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask
  task automatic wait_idle;
    logic [7:0] v;
    int n;
    v = 8'h04;
    n = 0;
    while (v[2] !== 1'b0 && n < 1000)
    begin
      rd(C0, v);
      n++;
    end
  endtask
  task automatic pulse;
    trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    logic [7:0] hi, lo;
    int p, t0, n0, w0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    foreach (ROWS[i])
      if (ROWS[i][16])
        wr(ROWS[i][15:8], ROWS[i][7:0]);
      else
        rdchk("row", ROWS[i][15:8], ROWS[i][7:0]);
    wr(adsc_pkg::OFF_PERIPH_EN, 8'h40);
    wr(adsc_pkg::OFF_INT_CTRL, 8'hC0);
    for (int i = 0; i < 6; i++)
    begin
      p = 2 << i;
      smp <= 10'h2B5 ^ 10'(i);
      wr(C1, {i[1], i[0], 6'h0E});
      wr(C0, {i[2:1], 3'(i % 5), 3'b001});
      wr(FL, 8'h00);
      chk("chan", 8'(i % 5), {5'h00, chan});
      t0 = cyc;
      wr(C0, {i[2:1], 3'(i % 5), 3'b101});
      wait_idle;
      chk("time", 8'h01, {7'h00, (cyc - t0 >= 9 * p &&
          cyc - t0 <= 10 * p + 12)});
      hi = i[1] ? {6'h00, smp[9:8]} : smp[9:2];
      lo = i[1] ? smp[7:0] : {smp[1:0], 6'h00};
      rdchk("res_hi", RH, hi);
      rdchk("res_lo", RL, lo);
      rdchk("flags", FL, 8'h40);
      chk("irq", 8'h01, {7'h00, irq});
      wr(FL, 8'h00);
      @(posedge clk);
      #1 chk("irq_off", 8'h00, {7'h00, irq});
      repeat (2 * p + 8) @(posedge clk);
    end
    smp <= 10'h0F0;
    wr(C0, 8'h89);
    wr(C0, 8'h8D);
    repeat (40) @(posedge clk);
    chk("hold", 8'h01, {7'h00, hold});
    wr(C0, 8'h89);
    repeat (800) @(posedge clk);
    chk("hold_off", 8'h00, {7'h00, hold});
    rdchk("abort_c0", C0, 8'h89);
    rdchk("abort_flag", FL, 8'h00);
    rdchk("abort_hi", RH, hi);
    wr(C1, 8'h8E);
    wr(C0, 8'h01);
    n0 = nclr;
    pulse;
    rdchk("trig_go", C0, 8'h05);
    wait_idle;
    rdchk("trig_lo", RL, 8'hF0);
    chk("clear1", 8'h01, 8'(nclr - n0));
    wr(C0, 8'h00);
    pulse;
    rdchk("off_go", C0, 8'h00);
    chk("clear2", 8'h02, 8'(nclr - n0));
    mode <= 4'hA;
    wr(C0, 8'h01);
    pulse;
    rdchk("mode_go", C0, 8'h01);
    chk("clear3", 8'h02, 8'(nclr - n0));
    mode <= 4'hB;
    wr(C0, 8'h81);
    wr(C0, 8'h85);
    repeat (10) @(posedge clk);
    slp <= 1'b1;
    repeat (10) @(posedge clk);
    chk("sleep_pwr", 8'h00, {7'h00, pwr});
    rdchk("sleep_c0", C0, 8'h81);
    slp <= 1'b0;
    repeat (80) @(posedge clk);
    // rc clock conversions in sleep, first with wake, then without
    smp <= 10'h155;
    w0 = nwk;
    wr(C0, 8'hC1);
    wr(C0, 8'hC5);
    slp <= 1'b1;
    wait_idle;
    repeat (2) @(posedge clk);
    chk("wake", 8'h01, 8'(nwk - w0));
    chk("rc_pwr", 8'h01, {7'h00, pwr});
    rdchk("rc_lo", RL, 8'h55);
    rdchk("rc_hi", RH, 8'h01);
    slp <= 1'b0;
    repeat (400) @(posedge clk);
    wr(adsc_pkg::OFF_PERIPH_EN, 8'h00);
    wr(C0, 8'hC5);
    slp <= 1'b1;
    wait_idle;
    repeat (2) @(posedge clk);
    chk("rc_down", 8'h00, {7'h00, pwr});
    rdchk("rc_c0", C0, 8'hC1);
    chk("no_wake", 8'h01, 8'(nwk - w0));
    slp <= 1'b0;
    repeat (400) @(posedge clk);
    wr(C0, 8'h85);
    repeat (20) @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("rst_c0", C0, 8'h00);
    chk("rst_dir", 8'hFF, dir);
    rdchk("rst_lo", RL, 8'h55);
    test_done;
  end
endmodule // adsc_control_tb
bind adsc_control adsc_control_props adsc_control_props_i (
  .clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
  .rdata_out(rdata_out), .compare_mode_in(compare_mode_in),
  .special_trigger_in(special_trigger_in), .channel_out(channel_out),
  .powered_out(powered_out), .port_a_direction_out(port_a_direction_out),
  .timer_clear_out(timer_clear_out), .sample_hold_out(sample_hold_out));
`default_nettype wire
